// ==== logic/irq_ctl_pkg.sv ====
package irq_ctl_pkg;

	// Number of request lines and how many of them have a wired source.
	localparam int unsigned NUM_LINES = 32;
	localparam int unsigned NUM_WIRED = 26;
	localparam int unsigned NUM_PERIPH = 22;
	localparam int unsigned NUM_EXT = 4;

	// First line fed by the external request pins.
	localparam int unsigned EXT_FIRST = 22;

	// Base address of the register window and the decoded part of it.
	localparam logic [31:0] BASE_ADDR = 32'h8030_0000;
	localparam int unsigned WIN_BITS = 8;

	// Register byte offsets inside the window.
	localparam logic [7:0] OFF_PENDING = 8'h00;
	localparam logic [7:0] OFF_SOFT_TRIG = 8'h04;
	localparam logic [7:0] OFF_SENSE = 8'h08;
	localparam logic [7:0] OFF_DEFER = 8'h0c;
	localparam logic [7:0] OFF_ENABLE = 8'h10;

	// Reset values of all registers.
	localparam logic [31:0] RST_PENDING = 32'h0000_0000;
	localparam logic [31:0] RST_SENSE = 32'h0000_0000;
	localparam logic [31:0] RST_DEFER = 32'h0000_0000;
	localparam logic [31:0] RST_ENABLE = 32'h0000_0000;

	// Access size codes on the size port.
	localparam logic [2:0] SIZE_BYTE = 3'h0;
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	// Value of a register bit that selects level sensitivity.
	localparam logic SENSE_LEVEL = 1'b1;

	// Returns the byte lanes that an access may touch; lanes past the
	// last byte of the addressed register are clipped away.
	function automatic logic [3:0] lane_mask(input logic [1:0] lane,
		input logic [2:0] size);
		logic [3:0] span;
		span = 4'h0;
		unique case (size)
			SIZE_BYTE: span = 4'h1;
			SIZE_HALF: span = 4'h3;
			SIZE_WORD: span = 4'hf;
			default: span = 4'h0;
		endcase
		lane_mask = span << lane;
	endfunction : lane_mask

	// Widens a lane mask to a bit mask.
	function automatic logic [31:0] bit_mask(input logic [3:0] lanes);
		bit_mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}},
			{8{lanes[0]}}};
	endfunction : bit_mask

endpackage : irq_ctl_pkg

// ==== logic/irq_ctl_unit.sv ====
// Notes on behaviour
// - thirty-two request inputs, twenty-six wired sources.
// - lines 0-12 timers, converter, serial ports, links.
// - lines 13-25 serial, bus, converters, external.
// - external requests only via selected pins.
// - no hardware priority between lines.
// - lines 26-31 unwired, all lines software triggerable.
// - byte, half-word and word accesses accepted.
// - larger-than-word access raises bus error.
// - an access never spills into next register.
// - five 32-bit registers at fixed base.
// - enable register gates each line.
// - sensitivity bit one means level, zero edge.
// - deferred lines wait while processor busy.
// - pending register reads current pending lines.
// - writing one acknowledges and clears pending.
// - soft trigger pends edge lines only.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module irq_ctl_unit (
	input wire logic clk, // System clock, 50 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [31:0] bus_addr, // Byte address of the access.
	input wire logic [31:0] bus_wdata, // Write data, lane aligned.
	input wire logic [2:0] bus_size, // Access size code.
	input wire logic bus_wr, // Write strobe.
	input wire logic bus_rd, // Read strobe.
	output logic [31:0] bus_rdata, // Read data, cycle after read.
	output logic bus_err, // Size error, cycle after access.
	input wire logic [irq_ctl_pkg::NUM_PERIPH-1:0] periph_req, // Peripherals.
	input wire logic [irq_ctl_pkg::NUM_EXT-1:0] external_request_line, // Pins.
	input wire logic [irq_ctl_pkg::NUM_EXT-1:0] ext_func_sel, // Pin in use.
	input wire logic cpu_busy, // Processor reports it is busy.
	output logic irq_out // Interrupt request to the processor.
);
	import irq_ctl_pkg::*;

	// Register file state.
	logic [31:0] pending_ack_reg; // Pending flags.
	logic [31:0] pending_ack_next; // Next pending flags.
	logic [31:0] sensitivity_select_reg; // One means level sensitive.
	logic [31:0] defer_mask_reg; // One means wait for idle processor.
	logic [31:0] line_enable_reg; // One means line may interrupt.
	logic [31:0] rdata_reg; // Registered read data.
	logic err_reg; // Registered bus error.

	// Two-stage synchroniser for the external pins.
	logic [NUM_EXT-1:0] ext_meta_reg; // First stage, read only by second.
	logic [NUM_EXT-1:0] ext_sync_reg; // Second stage, safe to use.

	// Previous sample of every line for edge detection.
	logic [31:0] line_prev_reg;

	// Address decode and lane selection.
	wire in_window; // Address falls in this block's window.
	wire size_ok; // Size is byte, half-word or word.
	wire [7:0] reg_off; // Word-aligned offset of the access.
	wire [31:0] wmask; // Bits the write may change.
	wire wr_ok; // Legal write inside the window.
	wire rd_ok; // Legal read inside the window.
	wire hit_pending; // Offset selects the pending register.
	wire hit_soft; // Offset selects the soft trigger register.
	wire hit_sense; // Offset selects the sensitivity register.
	wire hit_defer; // Offset selects the defer register.
	wire hit_enable; // Offset selects the enable register.
	wire [31:0] rd_word; // Word selected for a read.

	// Line sources and derived events.
	wire [NUM_EXT-1:0] ext_gated; // Pins whose alternate use is set.
	wire [31:0] line_raw; // All request lines in one vector.
	wire [31:0] rise; // Rising edges of the lines.
	wire [31:0] ack_bits; // Flags being acknowledged.
	wire [31:0] soft_bits; // Flags set by the soft trigger.
	wire [31:0] set_edge; // Set terms of edge-sensitive lines.
	wire [31:0] set_level; // Set terms of level-sensitive lines.
	wire [31:0] deliverable; // Lines allowed to interrupt now.

	// The window covers the base address and the low offset bits.
	assign in_window = bus_addr[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS];
	assign size_ok = bus_size <= SIZE_WORD;
	assign reg_off = {bus_addr[7:2], 2'b00};
	// Lanes past byte 3 are dropped, so a crossing write stays local.
	assign wmask = bit_mask(lane_mask(bus_addr[1:0], bus_size));
	assign wr_ok = bus_wr && in_window && size_ok;
	assign rd_ok = bus_rd && in_window && size_ok;
	assign hit_pending = reg_off == OFF_PENDING;
	assign hit_soft = reg_off == OFF_SOFT_TRIG;
	assign hit_sense = reg_off == OFF_SENSE;
	assign hit_defer = reg_off == OFF_DEFER;
	assign hit_enable = reg_off == OFF_ENABLE;

	// The soft trigger register holds nothing and reads as zero.
	assign rd_word = hit_pending ? pending_ack_reg :
		hit_sense ? sensitivity_select_reg :
		hit_defer ? defer_mask_reg :
		hit_enable ? line_enable_reg : 32'h0000_0000;

	// External pins count only when routed to the controller.
	assign ext_gated = ext_sync_reg & ext_func_sel;

	// Lines 0-21 peripherals, 22-25 pins, 26-31 have no source.
	assign line_raw = {{(NUM_LINES - NUM_WIRED){1'b0}}, ext_gated,
		periph_req};

	assign rise = line_raw & ~line_prev_reg;
	assign ack_bits = (wr_ok && hit_pending) ?
		(bus_wdata & wmask) : 32'h0000_0000;
	// Every line may be soft triggered, but only while edge sensitive.
	assign soft_bits = (wr_ok && hit_soft) ?
		(bus_wdata & wmask & ~sensitivity_select_reg) :
		32'h0000_0000;
	assign set_edge = (rise | soft_bits) & ~sensitivity_select_reg;
	assign set_level = line_raw & sensitivity_select_reg;

	// Sets win over a clear that arrives in the same cycle.
	assign pending_ack_next = (pending_ack_reg & ~ack_bits) | set_edge |
		set_level;

	// Deferred lines are held back while the processor is busy.
	assign deliverable = pending_ack_reg & line_enable_reg &
		~(defer_mask_reg & {32{cpu_busy}});

	// Any qualifying line raises the request; no line outranks another.
	assign irq_out = |deliverable;

	assign bus_rdata = rdata_reg;
	assign bus_err = err_reg;

	// Synchronises the external pins through two flip-flops.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_meta_reg <= '0;
			ext_sync_reg <= '0;
		end else begin
			ext_meta_reg <= external_request_line;
			ext_sync_reg <= ext_meta_reg;
		end
	end

	// Tracks line levels and the pending flags.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_prev_reg <= 32'h0000_0000;
			pending_ack_reg <= RST_PENDING;
		end else begin
			line_prev_reg <= line_raw;
			pending_ack_reg <= pending_ack_next;
		end
	end

	// Updates the configuration registers on legal writes, lane by lane.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sensitivity_select_reg <= RST_SENSE;
			defer_mask_reg <= RST_DEFER;
			line_enable_reg <= RST_ENABLE;
		end else if (wr_ok) begin
			if (hit_sense) begin
				sensitivity_select_reg <= (sensitivity_select_reg & ~wmask) |
					(bus_wdata & wmask);
			end
			if (hit_defer) begin
				defer_mask_reg <= (defer_mask_reg & ~wmask) |
					(bus_wdata & wmask);
			end
			if (hit_enable) begin
				line_enable_reg <= (line_enable_reg & ~wmask) |
					(bus_wdata & wmask);
			end
		end
	end

	// Returns read data and the size error one cycle after the strobe.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else begin
			rdata_reg <= rd_ok ? rd_word : 32'h0000_0000;
			err_reg <= (bus_wr || bus_rd) && in_window && !size_ok;
		end
	end

	// Checks on the behaviour of the controller.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_size_error: assert property (
		(bus_wr || bus_rd) && in_window && bus_size > SIZE_WORD |=>
		bus_err)
		else $error("oversize access gave no bus error");

	a_size_legal: assert property (
		(bus_wr || bus_rd) && bus_size <= SIZE_WORD |=> !bus_err)
		else $error("legal access gave a bus error");

	a_enable_gate: assert property (
		line_enable_reg == 32'h0000_0000 |-> !irq_out)
		else $error("request with every line disabled");

	a_defer_busy: assert property (
		cpu_busy && (pending_ack_reg & line_enable_reg &
		~defer_mask_reg) == 32'h0000_0000 |-> !irq_out)
		else $error("deferred line delivered while busy");

	a_edge_pends: assert property (
		!sensitivity_select_reg[0] && line_raw[0] && !line_prev_reg[0]
		|=> pending_ack_reg[0])
		else $error("rising edge did not pend line 0");

	a_level_holds: assert property (
		(sensitivity_select_reg[1] && line_raw[1]) [*2] |->
		pending_ack_reg[1])
		else $error("high level line not pending");

	a_ack_clears: assert property (
		bus_wr && in_window && reg_off == OFF_PENDING &&
		bus_addr[1:0] == 2'b00 && bus_size == SIZE_WORD &&
		bus_wdata == 32'hffff_ffff && line_raw == 32'h0000_0000
		|=> pending_ack_reg == 32'h0000_0000)
		else $error("acknowledge did not clear pending");

	a_soft_edge: assert property (
		bus_wr && in_window && reg_off == OFF_SOFT_TRIG &&
		bus_addr[1:0] == 2'b00 && bus_size == SIZE_WORD &&
		bus_wdata[31] && !sensitivity_select_reg[31]
		|=> pending_ack_reg[31])
		else $error("soft trigger did not pend line 31");

	a_soft_level: assert property (
		bus_wr && hit_soft && sensitivity_select_reg == 32'hffff_ffff &&
		line_raw == 32'h0000_0000 && pending_ack_reg == 32'h0000_0000
		|=> pending_ack_reg == 32'h0000_0000)
		else $error("soft trigger pended a level line");

	a_spare_quiet: assert property (
		line_raw[31:NUM_WIRED] == '0)
		else $error("unwired line shows a request");

	a_no_spill: assert property (
		bus_wr && hit_sense && bus_addr[1:0] != 2'b00 |=>
		$stable(defer_mask_reg))
		else $error("write spilled into next register");

	a_read_enable: assert property (
		rd_ok && hit_enable |=> bus_rdata == $past(line_enable_reg))
		else $error("enable readback mismatch");

	a_read_idle: assert property (
		!bus_rd |=> bus_rdata == 32'h0000_0000)
		else $error("read data outside the read slot");

	c_edge_irq: cover property (
		rise[0] && line_enable_reg[0] ##1 irq_out);
	c_soft_irq: cover property (
		wr_ok && hit_soft && bus_wdata[28] ##1 pending_ack_reg[28]);
	c_deferred: cover property (
		cpu_busy && |(pending_ack_reg & defer_mask_reg) ##1 !cpu_busy);
	c_ack_race: cover property (
		|(ack_bits & set_edge));

endmodule : irq_ctl_unit

`default_nettype wire

// ==== tb/irq_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module irq_source_model (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [irq_ctl_pkg::NUM_PERIPH-1:0] raise, // Source event.
	input wire logic [irq_ctl_pkg::NUM_PERIPH-1:0] clear, // Clear at source.
	output logic [irq_ctl_pkg::NUM_PERIPH-1:0] periph_req // Level requests.
);
	import irq_ctl_pkg::*;

	// Each peripheral holds its request until software clears it there.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			periph_req <= '0;
		end else begin
			periph_req <= (periph_req | raise) & ~clear;
		end
	end
endmodule : irq_source_model

`default_nettype wire

// ==== tb/irq_controller_32line_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module irq_controller_32line_bench;
	import irq_ctl_pkg::*;
	logic clk = 1'b0; // System clock.
	logic rst_n = 1'b0; // Reset, active low.
	logic [31:0] bus_addr = '0; // Bus address.
	logic [31:0] bus_wdata = '0; // Write data.
	logic [2:0] bus_size = '0; // Access size.
	logic bus_wr = 1'b0; // Write strobe.
	logic bus_rd = 1'b0; // Read strobe.
	logic [31:0] bus_rdata; // Read data.
	logic bus_err; // Size error.
	logic [21:0] raise = '0; // Source events.
	logic [21:0] clear = '0; // Source clears.
	logic [21:0] periph_req; // Peripheral requests.
	logic [3:0] pins = '0; // External pins.
	logic [3:0] fsel = '0; // Pin function select.
	logic cpu_busy = 1'b0; // Processor busy.
	logic irq_out; // Request to processor.
	int err_count = 0; // Mismatches.
	int compares = 0; // Comparisons.
	int seed; // Random seed.
	int n; // Chosen line.
	logic [31:0] d; // Random data.
	logic [31:0] b; // One-hot line bit.

	// Free-running 50 MHz clock.
	always #10 clk = ~clk;

	irq_source_model src (.clk(clk), .rst_n(rst_n), .raise(raise),
		.clear(clear), .periph_req(periph_req));

	irq_ctl_unit dut (.clk(clk), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_size(bus_size), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_err(bus_err),
		.periph_req(periph_req), .external_request_line(pins),
		.ext_func_sel(fsel), .cpu_busy(cpu_busy), .irq_out(irq_out));

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test;
		$display("counts: %0d compares, %0d mismatches", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: word %h, expected %h", $time, g, e);
		end
	endtask : chk_word

	task automatic chk_bit(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: bit %b, expected %b", $time, g, e);
		end
	endtask : chk_bit

	// Expected register after a write touching lanes lo..lo+k-1 only.
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] w, input int lo, input int k);
		for (int i = 0; i < 4; i++) begin
			if (i >= lo && i < lo + k) begin
				o[8*i +: 8] = w[8*i +: 8];
			end
		end
		return o;
	endfunction : merge

	// One write cycle; the error flag stands in the next cycle.
	task automatic wr(input logic [7:0] off, input logic [31:0] v,
		input logic [2:0] sz);
		@(posedge clk);
		bus_addr <= BASE_ADDR | {24'h0, off};
		bus_wdata <= v;
		bus_size <= sz;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
		#1;
		chk_bit(bus_err, sz > SIZE_WORD);
	endtask : wr

	// One read cycle; data is checked in the cycle after the strobe.
	task automatic rd(input logic [7:0] off, input logic [31:0] e);
		@(posedge clk);
		bus_addr <= BASE_ADDR | {24'h0, off};
		bus_size <= SIZE_WORD;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		chk_word(bus_rdata, e);
	endtask : rd

	task automatic pulse(input logic [21:0] r, input logic [21:0] c);
		@(posedge clk);
		raise <= r;
		clear <= c;
		@(posedge clk);
		raise <= '0;
		clear <= '0;
	endtask : pulse

	// Bounded wait for the interrupt output; a hang ends the run.
	task automatic wait_irq(input logic v);
		int k;
		k = 0;
		while (irq_out !== v && k < 8) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk_bit(irq_out, v);
		if (irq_out !== v) begin
			end_of_test();
		end
	endtask : wait_irq

	initial begin
		seed = 89;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h00, RST_PENDING);
		rd(8'h04, 32'h0);
		rd(8'h08, RST_SENSE);
		rd(8'h0c, RST_DEFER);
		rd(8'h10, RST_ENABLE);
		rd(8'h14, 32'h0);
		for (int i = 2; i < 5; i++) begin
			d = $random(seed);
			wr(8'(4 * i), d, SIZE_WORD);
			rd(8'(4 * i), d);
			wr(8'(4 * i), 32'h0, SIZE_WORD);
		end
		d = $random(seed);
		wr(8'h0a, d, SIZE_WORD);
		rd(8'h08, merge(32'h0, d, 2, 2));
		rd(8'h0c, 32'h0);
		wr(8'h0d, d, SIZE_HALF);
		rd(8'h0c, merge(32'h0, d, 1, 2));
		wr(8'h10, d, SIZE_BYTE);
		rd(8'h10, merge(32'h0, d, 0, 1));
		for (int s = 3; s < 8; s++) begin
			wr(8'h10, 32'hffff_ffff, 3'(s));
		end
		rd(8'h10, merge(32'h0, d, 0, 1));
		$display("test registers done");
		wr(8'h08, 32'h0, SIZE_WORD);
		wr(8'h0c, 32'h0, SIZE_WORD);
		wr(8'h10, 32'h0, SIZE_WORD);
		wr(8'h04, 32'hffff_ffff, SIZE_WORD);
		rd(8'h00, 32'hffff_ffff);
		chk_bit(irq_out, 1'b0);
		wr(8'h00, 32'h0, SIZE_WORD);
		rd(8'h00, 32'hffff_ffff);
		wr(8'h10, 32'hffff_ffff, SIZE_WORD);
		wait_irq(1'b1);
		wr(8'h00, 32'hffff_ffff, SIZE_WORD);
		rd(8'h00, 32'h0);
		wait_irq(1'b0);
		wr(8'h08, 32'hffff_ffff, SIZE_WORD);
		wr(8'h04, 32'hffff_ffff, SIZE_WORD);
		rd(8'h00, 32'h0);
		$display("test soft trigger done");
		n = $unsigned($random(seed)) % NUM_PERIPH;
		b = 32'h1 << n;
		wr(8'h08, 32'h0, SIZE_WORD);
		pulse(b[21:0], '0);
		wait_irq(1'b1);
		rd(8'h00, b);
		wr(8'h00, b, SIZE_WORD);
		rd(8'h00, 32'h0);
		wr(8'h08, b, SIZE_WORD);
		rd(8'h00, b);
		wr(8'h00, b, SIZE_WORD);
		rd(8'h00, b);
		pulse('0, b[21:0]);
		wr(8'h00, b, SIZE_WORD);
		rd(8'h00, 32'h0);
		$display("test peripheral line done");
		wr(8'h08, 32'h0, SIZE_WORD);
		wr(8'h0c, b, SIZE_WORD);
		cpu_busy <= 1'b1;
		pulse(b[21:0], '0);
		repeat (3) @(posedge clk);
		#1;
		chk_bit(irq_out, 1'b0);
		@(posedge clk);
		cpu_busy <= 1'b0;
		wait_irq(1'b1);
		pulse('0, b[21:0]);
		wr(8'h00, b, SIZE_WORD);
		wait_irq(1'b0);
		$display("test defer done");
		for (int k = 0; k < NUM_EXT; k++) begin
			b = 32'h1 << (EXT_FIRST + k);
			@(posedge clk);
			pins <= 4'h1 << k;
			repeat (5) @(posedge clk);
			#1;
			chk_bit(irq_out, 1'b0);
			@(posedge clk);
			fsel <= 4'h1 << k;
			wait_irq(1'b1);
			rd(8'h00, b);
			pins <= 4'h0;
			fsel <= 4'h0;
			wr(8'h00, b, SIZE_WORD);
			wait_irq(1'b0);
		end
		$display("test external lines done");
		end_of_test();
	end
endmodule : irq_controller_32line_bench

`default_nettype wire
